// [src/tws_pkg.sv]
// Shared constants and types for the two-wire serial memory slave
`default_nettype none
package tws_pkg;

    // ------------------------------------------------------------------
    // Memory geometry
    // ------------------------------------------------------------------
    localparam int MEM_DEPTH    = 2048;
    localparam int ADDR_W       = 11;
    localparam int DATA_W       = 8;
    localparam int PAGE_BYTES   = 16;
    localparam int PAGE_W       = 4;
    localparam int PAGE_BASE_W  = ADDR_W - PAGE_W;

    // ------------------------------------------------------------------
    // Slave address byte layout
    // ------------------------------------------------------------------
    localparam int DEV_ID_MSB   = 7;
    localparam int DEV_ID_LSB   = 4;
    localparam int HI_ADDR_MSB  = 3;
    localparam int HI_ADDR_LSB  = 1;
    localparam int RW_BIT       = 0;
    localparam int HI_ADDR_W    = HI_ADDR_MSB - HI_ADDR_LSB + 1;

    // Arbitrary device type value, not taken from any real part
    localparam logic [3:0] DEV_TYPE_ID = 4'h5;

    // ------------------------------------------------------------------
    // Bit counter positions inside one nine-clock byte slot, and the end index of the page commit
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [4:0] PAGE_END  = 5'h10;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0]      PTR_RST   = 11'h000;
    localparam logic [HI_ADDR_W-1:0]   HI_RST    = 3'h0;
    localparam logic [DATA_W-1:0]      BYTE_RST  = 8'h00;
    localparam logic [PAGE_BYTES-1:0]  MASK_RST  = 16'h0000;

    // ------------------------------------------------------------------
    // Timing: nonvolatile_write_period, longest time rounds down
    // ------------------------------------------------------------------
    localparam int NONVOLATILE_WRITE_PERIOD_MS = 5;
    localparam int CLK_FREQ_HZ                 = 10_000_000;
    localparam int NV_WRITE_CYCLES =
        NONVOLATILE_WRITE_PERIOD_MS * (CLK_FREQ_HZ / 1000);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_DEV,
        PH_WORD,
        PH_WDATA,
        PH_READ,
        PH_WAIT
    } tws_phase_t;

    typedef struct packed {
        logic start;
        logic stop;
        logic scl_fall;
        logic bit_ev;
    } tws_bus_ev_t;

endpackage
`default_nettype wire

// [src/tws_eeprom_slave.sv]
// Two-wire serial slave in front of a 2k x 8 nonvolatile memory
//
// Functional notes
// RULE1: 2048 bytes, 11-bit byte address
// RULE2: Slave only, never starts a transfer
// RULE3: Data stable while clock high
// RULE4: Falling data, clock high: START; rising: STOP
// RULE5: Release after eight bits; receiver acks ninth
// RULE6: Acknowledge only matching device type nibble
// RULE7: Acknowledge every byte of a write
// RULE8: Read: send byte, sample ack, continue
// RULE9: Read nack: stop sending, wait for STOP
// RULE10: Master sends slave address after START
// RULE11: Address byte bits 3..1 give high address
// RULE12: Address byte bit 0: one read
// RULE13: Byte write commits after STOP
// RULE14: Ignore bus during internal write
// RULE15: Page write up to sixteen bytes
// RULE16: Page write increments only low address bits
// RULE17: Over sixteen bytes wraps within page
// RULE18: Busy device ignores START, no ack
// RULE19: Counter holds last address plus one
// RULE20: Sequential read increments all bits, wraps
// RULE21: Write cycle timed by counter, max 5 ms
// RULE22: Word byte carries address bits 7..0
`timescale 1ns/1ps
`default_nettype none

module tws_eeprom_slave
#(
    parameter int         WR_CYCLES = tws_pkg::NV_WRITE_CYCLES,
    parameter logic [3:0] DEV_TYPE  = tws_pkg::DEV_TYPE_ID
)
(
    input  wire logic clk_in,
    input  wire logic arst_n_in,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output var  logic sda_out,
    output var  logic sda_oe_out,
    output var  logic write_busy_out
);

    import tws_pkg::*;

    localparam int TMR_W = $clog2(WR_CYCLES + 1);
    localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(WR_CYCLES - 1);
    localparam logic [TMR_W-1:0] TMR_ZERO = '0;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [ADDR_W-1:0] page_inc(
        input logic [ADDR_W-1:0] a
    );
        logic [PAGE_W-1:0] low;
        low = a[PAGE_W-1:0] + 4'h1;
        page_inc = {a[ADDR_W-1:PAGE_W], low};
    endfunction

    function automatic logic [ADDR_W-1:0] full_inc(
        input logic [ADDR_W-1:0] a
    );
        full_inc = a + 11'h001;
    endfunction

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem      [MEM_DEPTH];                     // [RULE1]
    logic [DATA_W-1:0] page_buf [PAGE_BYTES];

    // ------------------------------------------------------------------
    // Link clock domain: sample the data line on each rising clock
    // ------------------------------------------------------------------
    logic link_bit;
    logic link_tgl;

    // The bit stays put until the next rising edge, at least one full
    // clock period, so the system side may read it after the toggle
    // has crossed.
    always_ff @(posedge scl_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            link_bit <= 1'b0;
            link_tgl <= 1'b0;
        end
        else
        begin
            link_bit <= sda_in;                                  // [RULE3]
            link_tgl <= ~link_tgl;
        end
    end

    // ------------------------------------------------------------------
    // Synchronisers into the system clock domain
    // ------------------------------------------------------------------
    logic scl_m;
    logic scl_s;
    logic scl_q;
    logic sda_m;
    logic sda_s;
    logic sda_q;
    logic tgl_m;
    logic tgl_s;
    logic tgl_q;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_q <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_q <= 1'b1;
            tgl_m <= 1'b0;
            tgl_s <= 1'b0;
            tgl_q <= 1'b0;
        end
        else
        begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_q <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_q <= sda_s;
            tgl_m <= link_tgl;
            tgl_s <= tgl_m;
            tgl_q <= tgl_s;
        end
    end

    // ------------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------------
    tws_bus_ev_t ev;

    always_comb
    begin
        ev.start    = scl_s & scl_q & sda_q & ~sda_s;            // [RULE4]
        ev.stop     = scl_s & scl_q & ~sda_q & sda_s;            // [RULE4]
        ev.scl_fall = scl_q & ~scl_s;
        ev.bit_ev   = tgl_s ^ tgl_q;
    end

    // ------------------------------------------------------------------
    // Protocol state
    // ------------------------------------------------------------------
    tws_phase_t             phase;
    logic [3:0]             cnt;
    logic [DATA_W-1:0]      shreg;
    logic [DATA_W-1:0]      tx;
    logic                   ack_pend;
    logic [HI_ADDR_W-1:0]   hi_addr;
    logic [ADDR_W-1:0]      ptr;
    logic [PAGE_BASE_W-1:0] page_base;
    logic [PAGE_BYTES-1:0]  mask;
    logic                   busy;
    logic [TMR_W-1:0]       timer;
    logic [4:0]             commit_idx;

    logic [DATA_W-1:0]      rx_byte;
    logic                   byte_done;
    logic                   buf_we;
    logic                   stop_commit;
    logic                   busy_done;

    always_comb
    begin
        rx_byte     = {shreg[DATA_W-2:0], link_bit};
        byte_done   = !busy && !ev.start && !ev.stop && ev.bit_ev
                      && (cnt == BIT_LAST);
        buf_we      = byte_done && (phase == PH_WDATA);
        stop_commit = ev.stop && !busy && (mask != MASK_RST);    // [RULE13]
        busy_done   = busy && (timer == TMR_ZERO);
    end

    // ------------------------------------------------------------------
    // Byte framing, addressing and pointer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            phase     <= PH_IDLE;
            cnt       <= 4'h0;
            shreg     <= BYTE_RST;
            tx        <= BYTE_RST;
            ack_pend  <= 1'b0;
            hi_addr   <= HI_RST;
            ptr       <= PTR_RST;
            page_base <= '0;
            mask      <= MASK_RST;
        end
        else if (busy)
        begin
            // Inputs are dead during the write cycle; starts are dropped
            phase    <= PH_IDLE;                                 // [RULE14]
            cnt      <= 4'h0;                                    // [RULE18]
            ack_pend <= 1'b0;
            if (busy_done)
            begin
                mask <= MASK_RST;
            end
        end
        else if (ev.start)
        begin
            phase    <= PH_DEV;                                  // [RULE10]
            cnt      <= 4'h0;
            ack_pend <= 1'b0;
        end
        else if (ev.stop)
        begin
            phase    <= PH_IDLE;                                 // [RULE9]
            cnt      <= 4'h0;
            ack_pend <= 1'b0;
        end
        else if (ev.bit_ev && phase != PH_IDLE)
        begin
            if (cnt == BIT_ACK)
            begin
                cnt      <= 4'h0;
                ack_pend <= 1'b0;
                // Our own ack after a read address is not a master ack
                if (phase == PH_READ && !ack_pend)
                begin
                    if (!link_bit)
                    begin
                        tx  <= mem[ptr];                         // [RULE8]
                        ptr <= full_inc(ptr);                    // [RULE20]
                    end
                    else
                    begin
                        phase <= PH_WAIT;                        // [RULE9]
                    end
                end
            end
            else
            begin
                cnt   <= cnt + 4'h1;
                shreg <= rx_byte;
            end

            if (byte_done)
            begin
                case (phase)
                    PH_DEV:
                    begin
                        if (rx_byte[DEV_ID_MSB:DEV_ID_LSB] == DEV_TYPE)
                        begin
                            ack_pend <= 1'b1;                    // [RULE6]
                            if (rx_byte[RW_BIT])                 // [RULE12]
                            begin
                                // High bits of the byte are ignored here
                                phase <= PH_READ;                // [RULE11]
                                tx    <= mem[ptr];               // [RULE19]
                                ptr   <= full_inc(ptr);          // [RULE19]
                            end
                            else
                            begin
                                phase   <= PH_WORD;
                                hi_addr <=                       // [RULE11]
                                    rx_byte[HI_ADDR_MSB:HI_ADDR_LSB];
                            end
                        end
                        else
                        begin
                            phase <= PH_WAIT;
                        end
                    end
                    PH_WORD:
                    begin
                        ack_pend  <= 1'b1;                       // [RULE7]
                        ptr       <= {hi_addr, rx_byte};         // [RULE22]
                        page_base <= {hi_addr,
                                      rx_byte[DATA_W-1:PAGE_W]};
                        mask      <= MASK_RST;
                        phase     <= PH_WDATA;
                    end
                    PH_WDATA:
                    begin
                        ack_pend <= 1'b1;                        // [RULE7]
                        mask[ptr[PAGE_W-1:0]] <= 1'b1;           // [RULE15]
                        // Wraps inside the page, later bytes overwrite
                        ptr <= page_inc(ptr);              // [RULE16] [RULE17]
                    end
                    default:
                    begin
                        ack_pend <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Page buffer collects data until the write cycle commits it
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (buf_we)
        begin
            page_buf[ptr[PAGE_W-1:0]] <= rx_byte;                // [RULE15]
        end
    end

    // ------------------------------------------------------------------
    // Internal write cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy       <= 1'b0;
            timer      <= TMR_ZERO;
            commit_idx <= 5'h00;
        end
        else if (stop_commit)
        begin
            busy       <= 1'b1;                                  // [RULE13]
            timer      <= TMR_LOAD;                              // [RULE21]
            commit_idx <= 5'h00;
        end
        else if (busy)
        begin
            timer <= timer - TMR_W'(1);                          // [RULE21]
            if (busy_done)
            begin
                busy <= 1'b0;
            end
            if (commit_idx != PAGE_END)
            begin
                commit_idx <= commit_idx + 5'h01;
            end
        end
    end

    // One byte per system clock; needs at least sixteen busy cycles
    always_ff @(posedge clk_in)
    begin
        if (busy && commit_idx != PAGE_END
            && mask[commit_idx[PAGE_W-1:0]])
        begin
            mem[{page_base, commit_idx[PAGE_W-1:0]}] <=
                page_buf[commit_idx[PAGE_W-1:0]];                // [RULE15]
        end
    end

    // ------------------------------------------------------------------
    // Data line drive, changed only right after the clock falls
    // ------------------------------------------------------------------
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sda_oe_out <= 1'b0;
            sda_out    <= 1'b0;
        end
        else
        begin
            sda_out <= 1'b0;
            // The device answers only; it never opens a frame itself
            if (busy || ev.stop || ev.start)                     // [RULE2]
            begin
                sda_oe_out <= 1'b0;                              // [RULE14]
            end
            else if (ev.scl_fall)
            begin
                if (cnt == BIT_ACK)
                begin
                    sda_oe_out <= ack_pend;                      // [RULE5]
                end
                else if (phase == PH_READ)
                begin
                    sda_oe_out <= ~tx[3'(BIT_LAST - cnt)];       // [RULE8]
                end
                else
                begin
                    sda_oe_out <= 1'b0;                          // [RULE5]
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            write_busy_out <= 1'b0;
        end
        else
        begin
            write_busy_out <= stop_commit || (busy && !busy_done);
        end
    end

endmodule

`default_nettype wire

// [bench/tws_slave_monitor.sv]
// Port checker for the two-wire memory slave, bound to its top module
`timescale 1ns/1ps
`default_nettype none

module tws_slave_monitor
#(
    parameter int WR_CYCLES = 200
)
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic write_busy_out
);
    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    logic scl_q;
    logic sda_q;
    int   falls;
    int   busy_cnt;

    // Clock falls since the last START; the slave may not drive before 9
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            falls <= 0;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            if (scl_q && scl_in && sda_q && !sda_in)
                falls <= 0;
            else if (scl_q && !scl_in)
                falls <= falls + 1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            busy_cnt <= 0;
        else if (write_busy_out)
            busy_cnt <= busy_cnt + 1;
        else
            busy_cnt <= 0;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    a_open_drain_low: assert property (sda_out == 1'b0)
        else $error("data drive value is not zero");
    a_busy_silent: assert property (write_busy_out |-> !sda_oe_out)
        else $error("slave drives data during internal write");
    a_busy_length: assert property (
        $fell(write_busy_out) && busy_cnt > 0 |->
        busy_cnt >= WR_CYCLES - 1 && busy_cnt <= WR_CYCLES + 20)
        else $error("internal write length out of range");
    a_busy_bounded: assert property (busy_cnt <= WR_CYCLES + 20)
        else $error("internal write does not end");
    a_busy_on_idle: assert property ($rose(write_busy_out) |->
        scl_in && sda_in)
        else $error("internal write began while the bus was active");
    a_oe_scl_low: assert property ($rose(sda_oe_out) |->
        !scl_in && !$past(scl_in, 2))
        else $error("slave changed data while clock high");
    a_no_early_drive: assert property (sda_oe_out |-> falls >= 9)
        else $error("slave drove data before the address byte ended");
    a_ack_hold: assert property (
        $rose(sda_oe_out) |=> sda_oe_out [*4])
        else $error("slave drive did not hold through the clock low");
    a_reset_quiet: assert property ($rose(arst_n_in) |->
        !sda_oe_out && !write_busy_out)
        else $error("slave active right after reset");

    c_busy: cover property ($rose(write_busy_out));
    c_drive: cover property ($rose(sda_oe_out));
    c_long_frame: cover property (falls > 150);
endmodule

bind tws_eeprom_slave tws_slave_monitor #(.WR_CYCLES(WR_CYCLES)) u_mon
(
    .clk_in         (clk_in),
    .arst_n_in      (arst_n_in),
    .scl_in         (scl_in),
    .sda_in         (sda_in),
    .sda_out        (sda_out),
    .sda_oe_out     (sda_oe_out),
    .write_busy_out (write_busy_out)
);
`default_nettype wire

// [bench/tws_master_model.sv]
// Behavioural two-wire bus master that drives the serial memory slave
`timescale 1ns/1ps
`default_nettype none

module tws_master_model
#(
    parameter int QTR = 10
)
(
    input  wire logic       lk_in,
    input  wire logic       sda_in,
    input  wire logic       rec_in,
    output var  logic       scl_out,
    output var  logic       sda_oe_out,
    output var  logic       res_stb_out,
    output var  logic [8:0] res_out
);
    // Clock stands high between frames, data line released
    initial
    begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
        res_stb_out = 1'b0;
        res_out = 9'h000;
    end

    task automatic q();
        repeat (QTR) @(posedge lk_in);
    endtask

    task automatic emit(input logic [8:0] v);
        if (rec_in)
        begin
            res_out = v;
            res_stb_out = 1'b1;
            @(posedge lk_in);
            res_stb_out = 1'b0;
        end
    endtask

    // Sample in mid clock high, so slow slave data has long settled
    task automatic bit_tx(input logic b, output logic s);
        sda_oe_out = !b;
        q();
        scl_out = 1'b1;
        q();
        s = sda_in;
        q();
        scl_out = 1'b0;
        q();
    endtask

    task automatic start();
        sda_oe_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_oe_out = 1'b1;
        q();
        scl_out = 1'b0;
        q();
    endtask

    task automatic stop();
        sda_oe_out = 1'b1;
        q();
        scl_out = 1'b1;
        q();
        sda_oe_out = 1'b0;
        repeat (4) q();
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_tx(b[i], s);
        bit_tx(1'b1, ack);
        emit({ack, 8'h00});
    endtask

    task automatic rbyte(input logic m_ack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_tx(1'b1, d[i]);
        bit_tx(!m_ack, s);
        emit({1'b0, d});
    endtask
endmodule
`default_nettype wire

// [bench/tws_eeprom_slave_tb_top.sv]
// Self-checking bench for the two-wire serial memory slave
`timescale 1ns/1ps
`default_nettype none

module tws_eeprom_slave_tb_top;
    localparam int         WR    = 200;
    localparam logic [3:0] ID    = 4'h6; // Arbitrary device type value
    localparam int         LIMIT = 40000;

    logic       clk_in;
    logic       arst_n_in;
    logic       lk;
    logic       scl;
    logic       sda;
    logic       m_oe;
    logic       d_oe;
    logic       busy;
    logic       rec;
    logic       stb;
    logic [8:0] res;
    logic       ak;
    logic [7:0] d;
    logic [7:0] v;
    logic [8:0] expq [$];
    logic [7:0] mem [int];
    int         mismatches;
    int         comparisons;
    int         cycles;

    // Open-drain wire with pull-up
    assign sda = !(m_oe || d_oe);

    tws_eeprom_slave #(.WR_CYCLES(WR), .DEV_TYPE(ID)) dut
    (
        .clk_in         (clk_in),
        .arst_n_in      (arst_n_in),
        .scl_in         (scl),
        .sda_in         (sda),
        .sda_out        (),
        .sda_oe_out     (d_oe),
        .write_busy_out (busy)
    );

    tws_master_model mst
    (
        .lk_in       (lk),
        .sda_in      (sda),
        .rec_in      (rec),
        .scl_out     (scl),
        .sda_oe_out  (m_oe),
        .res_stb_out (stb),
        .res_out     (res)
    );

    initial
    begin
        clk_in = 1'b0;
        lk = 1'b0;
        arst_n_in = 1'b0;
        rec = 1'b1;
    end

    always #50 clk_in = !clk_in;
    always #32 lk = !lk;

    task automatic check(input string what, input logic [8:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] b, input logic nack);
        expq.push_back({nack, 8'h00});
        mst.wbyte(b, ak);
    endtask

    task automatic rd(input logic m_ack, input logic [7:0] e);
        expq.push_back({1'b0, e});
        mst.rbyte(m_ack, d);
    endtask

    // Polling attempts are not queued: their count depends on timing
    task automatic poll(input logic dir);
        int n;
        n = 0;
        ak = 1'b1;
        rec = 1'b0;
        while (ak && n < 20)
        begin
            mst.start();
            mst.wbyte({ID, 3'b111, dir}, ak);
            if (ak)
                mst.stop();
            n++;
        end
        rec = 1'b1;
        check("poll", {8'h00, ak}, 9'h000);
    endtask

    always @(posedge stb)
    begin
        if (expq.size() == 0)
        begin
            mismatches++;
            $display("BAD result expected none seen %h", res);
        end
        else
            check("result", res, expq.pop_front());
    end

    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            mismatches++;
            results();
        end
    end

    initial
    begin
        void'($urandom(92917));
        repeat (2) @(negedge clk_in);
        arst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        mst.start();
        wr({~ID, 4'h0}, 1'b1);
        mst.stop();
        v = 8'($urandom());
        mem[0] = v;
        mst.start();
        wr({ID, 3'b000, 1'b0}, 1'b0);
        wr(8'h00, 1'b0);
        wr(v, 1'b0);
        mst.stop();
        @(negedge clk_in);
        check("busy", {8'h00, busy}, 9'h001);
        mst.start();
        wr({ID, 4'h0}, 1'b1);
        mst.stop();
        poll(1'b0);
        mst.stop();
        mst.start();
        wr({ID, 3'b111, 1'b0}, 1'b0);
        wr(8'hF0, 1'b0);
        for (int i = 0; i < 18; i++)
        begin
            v = 8'($urandom());
            mem[12'h7F0 + i % 16] = v;
            wr(v, 1'b0);
        end
        mst.stop();
        poll(1'b1);
        rd(1'b0, mem[12'h7F2]);
        mst.stop();
        mst.start();
        wr({ID, 3'b111, 1'b0}, 1'b0);
        wr(8'hFE, 1'b0);
        mst.start();
        wr({ID, 3'($urandom()), 1'b1}, 1'b0);
        rd(1'b1, mem[12'h7FE]);
        rd(1'b1, mem[12'h7FF]);
        rd(1'b0, mem[0]);
        rd(1'b1, 8'hFF);
        mst.stop();
        repeat (10) @(negedge clk_in);
        check("pending", 9'(expq.size()), 9'h000);
        results();
    end
endmodule
`default_nettype wire
